/* File: rtl/pin_mux_regs.svh */
// Register offsets, field positions and reset values of the pin mux.
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

`define PMX_OFS_DIR         8'h00
`define PMX_OFS_SEL         8'h04
`define PMX_OFS_AEN         8'h08
`define PMX_OFS_OUT         8'h0C
`define PMX_OFS_IN          8'h10
`define PMX_OFS_TMR         8'h14

`define PMX_RST_DIR         8'h00
`define PMX_RST_SEL         8'h00
`define PMX_RST_AEN         8'h00
`define PMX_RST_OUT         8'h00

// Analog-enable bits start at bit 4; pin 3 uses bit 4
`define PMX_AEN_FIRST_BIT   4
`define PMX_AEN_FIRST_PIN   3
`define PMX_AEN_LAST_PIN    6
`define PMX_ANALOG_CH_BASE  12

`endif

/* File: rtl/pin_mux_pkg.sv */
// Types shared by the pin mux files.
`default_nettype none
package pin_mux_pkg;
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] schmitt_en;
        logic [3:0] analog_sel;
    } pad_drive_t;

    typedef struct packed {
        logic capture_input_ch0_a;
        logic capture_input_ch1_a;
        logic capture_input_ch2_a;
        logic capture_input_ch0_b;
        logic capture_input_ch1_b;
        logic timer_output_hiz_control;
        logic timer_external_clock_in;
    } timer_in_t;

    typedef struct packed {
        logic timer_compare_out_ch0;
        logic timer_compare_out_ch1;
        logic timer_compare_out_ch2;
    } timer_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b10
    } bus_phase_t;
endpackage : pin_mux_pkg
`default_nettype wire

/* File: rtl/pin_input_sync.sv */
// Two-stage synchroniser for the eight pad inputs.
`default_nettype none
module pin_input_sync (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Pad levels and their synchronised copies
    input  wire logic [7:0] pad_in,
    output var  logic [7:0] pad_sync
);
    logic [7:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    meta_r[g]   <= 1'b0;
                    pad_sync[g] <= 1'b0;
                end else begin
                    meta_r[g]   <= pad_in[g];
                    pad_sync[g] <= meta_r[g];
                end
            end
        end
    endgenerate
endmodule : pin_input_sync
`default_nettype wire

/* File: rtl/port4_pin_function_mux.sv */
// Port four pin function multiplexer with AHB-Lite register slave.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`include "pin_mux_regs.svh"
`default_nettype none

// Behaviour
// RQ1 - Select 0: plain I/O, direction 0 input, 1 output; default after reset.
// RQ2 - Pins 0-2 select 1: input feeds capture A ch0-2, output drives compare.
// RQ3 - Pins 3-4 select 1: input feeds capture B ch0-1, output drives compare.
// RQ4 - Pins 3-6 map to analog channels 12-15 via analog-enable bits 4-7.
// RQ5 - Analog-enable 1 overrides all; driver and Schmitt input are disabled.
// RQ6 - Pin 5 select 1, direction 1, analog off drives compare out ch2.
// RQ7 - Pin 6 select 1: input feeds hi-z control; output held at ground.
// RQ8 - Pin 7 select 1: input feeds external clock; output held at ground.
// RQ9 - Select 1 with direction 0 keeps driver off; synced level feeds timer.
module port4_pin_function_mux (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output var  logic [31:0]             hrdata,
    output var  logic                    hreadyout,
    output var  logic                    hresp,
    // Port pins
    input  wire logic [7:0]              pad_in,
    output var  pin_mux_pkg::pad_drive_t pad_drive,
    // Timer side
    input  wire pin_mux_pkg::timer_out_t timer_out,
    output var  pin_mux_pkg::timer_in_t  timer_in
);
    // ==========================================================
    // Registers
    logic [7:0] port_four_direction_bits_r;
    logic [7:0] port_four_function_select_bits_r;
    logic [7:0] analog_enable_upper_bits_r;
    logic [7:0] out_data_r;
    logic [7:0] pad_sync;
    logic [7:0] pad_level_nxt;
    logic [7:0] pad_oe_nxt;
    logic [7:0] analog_on;
    logic [7:0] pad_o_r;
    logic [7:0] pad_oe_r;
    pin_mux_pkg::bus_phase_t phase_r;
    logic [7:0]              addr_r;

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_r <= pin_mux_pkg::BUS_IDLE;
            addr_r  <= 8'h00;
        end else if (hready) begin
            if (hsel && htrans[1]) begin
                phase_r <= hwrite ? pin_mux_pkg::BUS_WRITE : pin_mux_pkg::BUS_READ;
                addr_r  <= haddr;
            end else begin
                phase_r <= pin_mux_pkg::BUS_IDLE;
            end
        end
    end

    // Reset leaves every pin a plain input [RQ1]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_four_direction_bits_r        <= `PMX_RST_DIR; // [RQ1]
            port_four_function_select_bits_r  <= `PMX_RST_SEL; // [RQ1]
            analog_enable_upper_bits_r        <= `PMX_RST_AEN;
            out_data_r                        <= `PMX_RST_OUT;
        end else if (phase_r == pin_mux_pkg::BUS_WRITE) begin
            unique case (addr_r)
                `PMX_OFS_DIR: port_four_direction_bits_r       <= hwdata[7:0];
                `PMX_OFS_SEL: port_four_function_select_bits_r <= hwdata[7:0];
                `PMX_OFS_AEN: analog_enable_upper_bits_r       <= hwdata[7:0];
                `PMX_OFS_OUT: out_data_r                       <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data comes combinationally in the data phase; unmapped reads zero
    always_comb begin
        hrdata = 32'h0000_0000;
        if (phase_r == pin_mux_pkg::BUS_READ) begin
            unique case (addr_r)
                `PMX_OFS_DIR: hrdata = {24'h00_0000, port_four_direction_bits_r};
                `PMX_OFS_SEL: hrdata = {24'h00_0000, port_four_function_select_bits_r};
                `PMX_OFS_AEN: hrdata = {24'h00_0000, analog_enable_upper_bits_r};
                `PMX_OFS_OUT: hrdata = {24'h00_0000, out_data_r};
                `PMX_OFS_IN:  hrdata = {24'h00_0000, pad_sync};
                `PMX_OFS_TMR: hrdata = {29'h0000_0000, timer_out};
                default:      hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Input synchroniser
    pin_input_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pad_in   (pad_in),
        .pad_sync (pad_sync)
    );

    // ==========================================================
    // Analog ownership of pins 3 to 6 [RQ4]
    always_comb begin
        analog_on = 8'h00;
        for (int p = `PMX_AEN_FIRST_PIN; p <= `PMX_AEN_LAST_PIN; p++) begin
            analog_on[p] = analog_enable_upper_bits_r[p - `PMX_AEN_FIRST_PIN
                                                      + `PMX_AEN_FIRST_BIT]; // [RQ4]
        end
    end

    // ==========================================================
    // Per-pin output selection
    always_comb begin
        pad_level_nxt = out_data_r;
        pad_oe_nxt    = port_four_direction_bits_r; // [RQ1]
        for (int p = 0; p < 8; p++) begin
            if (port_four_function_select_bits_r[p]) begin
                pad_oe_nxt[p] = port_four_direction_bits_r[p]; // [RQ9]
                unique case (p)
                    0, 3: pad_level_nxt[p] = timer_out.timer_compare_out_ch0; // [RQ2] [RQ3]
                    1, 4: pad_level_nxt[p] = timer_out.timer_compare_out_ch1; // [RQ2] [RQ3]
                    2, 5: pad_level_nxt[p] = timer_out.timer_compare_out_ch2; // [RQ2] [RQ6]
                    default: pad_level_nxt[p] = 1'b0; // [RQ7] [RQ8]
                endcase
            end
            if (analog_on[p]) begin
                pad_oe_nxt[p]    = 1'b0; // [RQ5]
                pad_level_nxt[p] = 1'b0;
            end
        end
    end

    // Pad data from flip-flops; one cycle behind the controls
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pad_o_r  <= 8'h00;
            pad_oe_r <= 8'h00;
        end else begin
            pad_o_r  <= pad_level_nxt;
            pad_oe_r <= pad_oe_nxt;
        end
    end

    // One driver for the whole struct; field-wise mixed drivers are illegal
    assign pad_drive = '{o:          pad_o_r,
                         oe:         pad_oe_r,
                         schmitt_en: ~analog_on,                        // [RQ5]
                         analog_sel: analog_enable_upper_bits_r[7:4]};  // [RQ4]

    // ==========================================================
    // Timer inputs from the synchronised pad levels; gated off otherwise
    always_comb begin
        logic [7:0] cap;
        cap = pad_sync & port_four_function_select_bits_r
              & ~port_four_direction_bits_r & ~analog_on; // [RQ9]
        timer_in.capture_input_ch0_a      = cap[0]; // [RQ2]
        timer_in.capture_input_ch1_a      = cap[1]; // [RQ2]
        timer_in.capture_input_ch2_a      = cap[2]; // [RQ2]
        timer_in.capture_input_ch0_b      = cap[3]; // [RQ3]
        timer_in.capture_input_ch1_b      = cap[4]; // [RQ3]
        timer_in.timer_output_hiz_control = cap[6]; // [RQ7]
        timer_in.timer_external_clock_in  = cap[7]; // [RQ8]
    end

    // ==========================================================
    // Assertions
    property p_io_default;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r == 8'h00 && analog_enable_upper_bits_r == 8'h00)
        |=> pad_drive.oe == $past(port_four_direction_bits_r)
            && pad_drive.o == $past(out_data_r);
    endproperty
    a_io_default: assert property (p_io_default) else $error("plain I/O wrong"); // [RQ1]

    property p_cap_a;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[1] && !port_four_direction_bits_r[1])
        |-> timer_in.capture_input_ch1_a == pad_sync[1];
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture A ch1 not routed"); // [RQ2]

    property p_cap_b;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[3] && !port_four_direction_bits_r[3]
         && !analog_on[3]) |-> timer_in.capture_input_ch0_b == pad_sync[3];
    endproperty
    a_cap_b: assert property (p_cap_b) else $error("capture B ch0 not routed"); // [RQ3]

    property p_cmp_out;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[4] && port_four_direction_bits_r[4] && !analog_on[4])
        |=> pad_drive.oe[4] && pad_drive.o[4] == $past(timer_out.timer_compare_out_ch1);
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("pin 4 compare out wrong"); // [RQ3]

    property p_analog_off;
        @(posedge core_clk) disable iff (rst)
        analog_enable_upper_bits_r[7] |-> !pad_drive.schmitt_en[6] ##1 !pad_drive.oe[6];
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog pin driven"); // [RQ5]

    property p_pin5;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[5] && port_four_direction_bits_r[5]
         && !analog_enable_upper_bits_r[6])
        |=> pad_drive.o[5] == $past(timer_out.timer_compare_out_ch2);
    endproperty
    a_pin5: assert property (p_pin5) else $error("pin 5 compare out wrong"); // [RQ6]

    property p_gnd;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[7] && port_four_direction_bits_r[7])
        |=> pad_drive.oe[7] && !pad_drive.o[7];
    endproperty
    a_gnd: assert property (p_gnd) else $error("pin 7 not at ground"); // [RQ8]

    property p_hiz;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[6] && !port_four_direction_bits_r[6]
         && !analog_on[6]) |-> timer_in.timer_output_hiz_control == pad_sync[6];
    endproperty
    a_hiz: assert property (p_hiz) else $error("hi-z control not routed"); // [RQ7]

    property p_in_no_drive;
        @(posedge core_clk) disable iff (rst)
        (port_four_function_select_bits_r[0] && !port_four_direction_bits_r[0])
        |=> !pad_drive.oe[0];
    endproperty
    a_in_no_drive: assert property (p_in_no_drive) else $error("input pin driven"); // [RQ9]
endmodule : port4_pin_function_mux
`default_nettype wire

/* File: tb/timer_side_model.sv */
// Behavioural model of the timer's compare outputs as seen by the pin mux.
`default_nettype none
module timer_side_model (
    // Clock
    input  wire logic                    core_clk,
    // Compare levels asked for by the bench, ch0 in bit 2
    input  wire logic [2:0]              cmp_level,
    // Compare outputs into the mux
    output var  pin_mux_pkg::timer_out_t timer_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Registered like a real compare unit, so levels move only after an edge
    always_ff @(posedge core_clk) begin
        timer_out <= pin_mux_pkg::timer_out_t'(cmp_level);
    end
endmodule : timer_side_model
`default_nettype wire

/* File: tb/port4_pin_function_mux_tb.sv */
// Self-checking testbench of the port four pin function multiplexer.
`include "pin_mux_regs.svh"
`default_nettype none
module port4_pin_function_mux_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Signals
    logic                    core_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    hsel = 1'b0;
    logic [7:0]              haddr = 8'h00;
    logic [1:0]              htrans = 2'h0;
    logic                    hwrite = 1'b0;
    logic [31:0]             hwdata = 32'h0;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic [7:0]              pad_in = 8'h00;
    logic [2:0]              cmp_level = 3'h0;
    pin_mux_pkg::pad_drive_t pad_drive;
    pin_mux_pkg::timer_out_t timer_out;
    pin_mux_pkg::timer_in_t  timer_in;
    int                      n_mismatch = 0;
    int                      n_compared = 0;
    int                      cycles = 0;
    logic [31:0]             rd;

    always #25 core_clk = ~core_clk;

    port4_pin_function_mux u_port4_pin_function_mux (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
        .pad_drive(pad_drive), .timer_out(timer_out), .timer_in(timer_in));

    timer_side_model u_timer_side_model (
        .core_clk(core_clk), .cmp_level(cmp_level), .timer_out(timer_out));

    // ==========================================
    // Shared tasks
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // No bound on the waits here: the cycle ceiling below cuts a hang short
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ==========================================
    // Scenarios
    task automatic t_reset_defaults();
        settle(1);
        chk({pad_drive.o, pad_drive.oe}, 32'h0);
        chk(timer_in, 32'h0);
        bus(1'b0, `PMX_OFS_SEL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'hF0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("reset defaults done");
    endtask : t_reset_defaults

    task automatic t_plain_io();
        bus(1'b1, `PMX_OFS_OUT, 32'hA5);
        bus(1'b1, `PMX_OFS_DIR, 32'hFF);
        settle(2);
        chk({pad_drive.o, pad_drive.oe}, 32'hA5FF);
        chk(timer_in, 32'h0);
        bus(1'b1, `PMX_OFS_DIR, 32'h00);
        pad_in <= 8'h3C;
        settle(3);
        chk(pad_drive.oe, 32'h0);
        bus(1'b0, `PMX_OFS_IN, 32'h0);
        chk(rd, 32'h3C);
        $display("plain io done");
    endtask : t_plain_io

    task automatic t_timer_inputs();
        logic [7:0] p;
        bus(1'b1, `PMX_OFS_SEL, 32'hFF);
        for (int i = 0; i < 2; i++) begin
            p = i ? 8'h5A : 8'hA5;
            @(posedge core_clk);
            pad_in <= p;
            settle(3);
            chk(timer_in, {p[0], p[1], p[2], p[3], p[4], p[6], p[7]});
            chk(pad_drive.oe, 32'h0);
        end
        $display("timer inputs done");
    endtask : t_timer_inputs

    task automatic t_timer_outputs();
        logic [2:0] c;
        bus(1'b1, `PMX_OFS_DIR, 32'hFF);
        for (int i = 0; i < 2; i++) begin
            // Asymmetric levels so a swap of ch0 and ch2 shows up
            c = i ? 3'b011 : 3'b100;
            @(posedge core_clk);
            cmp_level <= c;
            settle(3);
            chk(pad_drive.o, {2'b00, c[0], c[1], c[2], c[0], c[1], c[2]});
            chk(pad_drive.oe, 32'hFF);
            bus(1'b0, `PMX_OFS_TMR, 32'h0);
            chk(rd, {29'h0, c});
        end
        $display("timer outputs done");
    endtask : t_timer_outputs

    task automatic t_analog_override();
        bus(1'b1, `PMX_OFS_AEN, 32'hF0);
        settle(2);
        chk(pad_drive.analog_sel, 32'hF);
        chk(pad_drive.schmitt_en, 32'h87);
        chk(pad_drive.oe, 32'h87);
        bus(1'b1, `PMX_OFS_DIR, 32'h00);
        pad_in <= 8'hFF;
        settle(3);
        chk(timer_in, 7'b1110001);
        bus(1'b1, `PMX_OFS_AEN, 32'h00);
        settle(2);
        chk(timer_in, 7'b1111111);
        chk(pad_drive.schmitt_en, 32'hFF);
        $display("analog override done");
    endtask : t_analog_override

    // ==========================================
    // Sequence and watchdog
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_defaults();
        t_plain_io();
        t_timer_inputs();
        t_timer_outputs();
        t_analog_override();
        tally_and_finish();
    end
endmodule : port4_pin_function_mux_tb
`default_nettype wire
